// ===== pd_ext_pkg.sv
// package for the extended policy sequences and downstream-to-upstream role swap
// assumes one 200 MHz clock shared by the engine, the protocol layer and the policy manager
package pd_ext_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // response wait time, no figure fixed here; plain default in microseconds
    localparam int unsigned RESP_TIME_US  = 30;
    localparam int unsigned RESP_CYCLES   = (RESP_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned TMR_W         = 24;
    localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
    localparam logic [TMR_W-1:0] TMR_ONE  = 24'h000001;

    // message codes, both sent and received
    typedef enum logic [3:0] {
        MSG_NONE,
        MSG_GET_BATT_STATUS,
        MSG_BATT_STATUS,
        MSG_GET_MAKER_INFO,
        MSG_MAKER_INFO,
        MSG_SEC_REQUEST,
        MSG_SEC_RESPONSE,
        MSG_DR_SWAP,
        MSG_ACCEPT,
        MSG_REJECT,
        MSG_WAIT
    } msg_t;

    // outcome reported to the policy manager
    typedef enum logic [1:0] {
        OUT_NONE,
        OUT_OK,
        OUT_TIMEOUT
    } outcome_t;

    typedef enum logic [1:0] {
        RDY_SRC,
        RDY_SNK,
        RDY_CBL
    } ready_t;
endpackage

// ===== pd_ext_engine.sv
// policy engine slice: battery status, maker info, security and DFP-to-UFP role swap
// assumes protocol layer and policy manager sit on the same clock; their strobes are
// one-cycle pulses and need no synchroniser
//
// Overview of operation
// - battery status request: send query, run response timer, report outcome, back to ready
// - received battery query: fetch status from manager, send it, back to ready
// - maker info request: send query, run response timer, report outcome on exit
// - received maker info query in any ready: fetch info, send, return to origin
// - security request from manager: send it, back to ready, no timer
// - received security request in any ready: fetch reply, send response, return
// - received security response: inform manager, back to ready
// - dual-role port uses this one engine for source and sink; hard reset restores defaults
// - data role swap starts only from source-ready or sink-ready
// - swap request as DFP with no alternate modes goes to evaluation
// - swap request with alternate modes active goes to hard reset
// - manager swap demand moves ready to swap initiation
// - on entering evaluation, ask manager whether swap is acceptable
// - manager approval moves evaluation to accept
// - refusal or need for more time moves evaluation to reject
// - accept state sends Accept, then enters change-to-upstream
// - change-to-upstream asks manager to switch role; ready once confirmed
// - swap initiation sends swap request, starts timer, stops it on exit
// - Reject, Wait or timeout in initiation keeps DFP role, back to ready
// - reject state sends Reject or Wait, stays DFP, ready once sent
`timescale 1ns/1ps
module pd_ext_engine
    import pd_ext_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    // port role and mode status
    input  wire logic              i_role_is_sink,
    input  wire logic              i_cable_plug,
    input  wire logic              i_alt_mode_active,
    input  wire logic              i_hard_reset_done,
    // policy manager requests and answers
    input  wire logic              i_pm_get_batt,
    input  wire logic              i_pm_get_maker,
    input  wire logic              i_pm_send_sec,
    input  wire logic              i_pm_dr_swap,
    input  wire logic              i_pm_data_ready,
    input  wire logic              i_pm_swap_ok,
    input  wire logic              i_pm_swap_no,
    input  wire logic              i_pm_swap_wait,
    input  wire logic              i_pm_role_done,
    input  wire logic              i_pm_sec_ack,
    // protocol layer receive and transmit status
    input  wire pd_ext_pkg::msg_t  i_rx_msg,
    input  wire logic              i_rx_valid,
    input  wire logic              i_tx_done,
    // protocol layer transmit request
    output logic                   o_tx_req,
    output pd_ext_pkg::msg_t       o_tx_msg,
    // policy manager notices
    output logic                   o_pm_fetch_req,
    output logic                   o_pm_eval_req,
    output logic                   o_pm_role_req,
    output logic                   o_pm_sec_info,
    output pd_ext_pkg::outcome_t   o_pm_outcome,
    output logic                   o_pm_outcome_vld,
    output logic                   o_hard_reset_req,
    output logic                   o_is_ufp,
    output logic                   o_timer_run
);
    import pd_ext_pkg::*;

    typedef enum logic [4:0] {
        ST_READY,
        ST_HARD_RESET,
        query_battery_status_state,
        answer_battery_status_state,
        query_maker_info_state,
        answer_maker_info_state,
        ST_SEND_SEC_REQ,
        ST_SEND_SEC_RSP,
        ST_SEC_RSP_RCVD,
        swap_evaluation_state,
        swap_accept_state,
        swap_reject_state,
        change_to_upstream_state,
        swap_initiation_state
    } state_t;

    state_t            state_q, state_d;
    logic              sent_q;          // message for this state already handed over
    logic [TMR_W-1:0]  tmr_q;
    logic              ufp_q;
    logic              tx_req_q;
    msg_t              tx_msg_q;
    logic              fetch_q, eval_q, role_q, sec_q, outv_q, hr_q;
    outcome_t          out_q;

    function automatic logic is_rx(input logic v, input msg_t m, input msg_t want);
        return v && (m == want);
    endfunction

    wire rx_get_batt  = is_rx(i_rx_valid, i_rx_msg, MSG_GET_BATT_STATUS);
    wire rx_batt      = is_rx(i_rx_valid, i_rx_msg, MSG_BATT_STATUS);
    wire rx_get_maker = is_rx(i_rx_valid, i_rx_msg, MSG_GET_MAKER_INFO);
    wire rx_maker     = is_rx(i_rx_valid, i_rx_msg, MSG_MAKER_INFO);
    wire rx_sec_req   = is_rx(i_rx_valid, i_rx_msg, MSG_SEC_REQUEST);
    wire rx_sec_rsp   = is_rx(i_rx_valid, i_rx_msg, MSG_SEC_RESPONSE);
    wire rx_dr_swap   = is_rx(i_rx_valid, i_rx_msg, MSG_DR_SWAP);
    wire rx_accept    = is_rx(i_rx_valid, i_rx_msg, MSG_ACCEPT);
    wire rx_rej_wait  = is_rx(i_rx_valid, i_rx_msg, MSG_REJECT)
                      || is_rx(i_rx_valid, i_rx_msg, MSG_WAIT);
    wire tmr_expired  = (tmr_q == TMR_ONE);
    // a cable plug only answers; it never starts requests or swaps
    wire port_ready   = (state_q == ST_READY) && !i_cable_plug;
    wire entering     = (state_d != state_q);

    // message for the state being entered; one-cycle request on entry
    msg_t tx_entry;
    always_comb begin
        tx_entry = MSG_NONE;
        unique case (state_d)
            query_battery_status_state:  tx_entry = MSG_GET_BATT_STATUS;
            query_maker_info_state:      tx_entry = MSG_GET_MAKER_INFO;
            ST_SEND_SEC_REQ:             tx_entry = MSG_SEC_REQUEST;
            swap_accept_state:           tx_entry = MSG_ACCEPT;
            swap_initiation_state:       tx_entry = MSG_DR_SWAP;
            default:                     tx_entry = MSG_NONE;
        endcase
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_READY: begin
                if (rx_dr_swap && !i_cable_plug && !ufp_q) begin
                    if (i_alt_mode_active)
                        state_d = ST_HARD_RESET;
                    else
                        state_d = swap_evaluation_state;
                end else if (rx_get_batt && !i_cable_plug)
                    state_d = answer_battery_status_state;
                else if (rx_get_maker)
                    state_d = answer_maker_info_state;
                else if (rx_sec_req)
                    state_d = ST_SEND_SEC_RSP;
                else if (rx_sec_rsp && !i_cable_plug)
                    state_d = ST_SEC_RSP_RCVD;
                else if (port_ready && i_pm_dr_swap && !ufp_q)
                    state_d = swap_initiation_state;
                else if (port_ready && i_pm_get_batt)
                    state_d = query_battery_status_state;
                else if (port_ready && i_pm_get_maker)
                    state_d = query_maker_info_state;
                else if (port_ready && i_pm_send_sec)
                    state_d = ST_SEND_SEC_REQ;
            end
            ST_HARD_RESET:
                if (i_hard_reset_done) state_d = ST_READY;
            query_battery_status_state:
                if (rx_batt || tmr_expired) state_d = ST_READY;
            query_maker_info_state:
                if (rx_maker || tmr_expired) state_d = ST_READY;
            answer_battery_status_state, answer_maker_info_state, ST_SEND_SEC_RSP:
                if (sent_q && i_tx_done) state_d = ST_READY;
            ST_SEND_SEC_REQ:
                if (i_tx_done) state_d = ST_READY;
            ST_SEC_RSP_RCVD:
                if (i_pm_sec_ack) state_d = ST_READY;
            swap_evaluation_state:
                if (i_pm_swap_ok)
                    state_d = swap_accept_state;
                else if (i_pm_swap_no || i_pm_swap_wait)
                    state_d = swap_reject_state;
            swap_accept_state:
                if (i_tx_done) state_d = change_to_upstream_state;
            swap_reject_state:
                if (i_tx_done) state_d = ST_READY;
            change_to_upstream_state:
                if (i_pm_role_done) state_d = ST_READY;
            swap_initiation_state:
                if (rx_accept)
                    state_d = change_to_upstream_state;
                else if (rx_rej_wait || tmr_expired)
                    state_d = ST_READY;
            default: state_d = ST_READY;
        endcase
    end

    wire answer_entry = entering && ((state_d == answer_battery_status_state)
                      || (state_d == answer_maker_info_state) || (state_d == ST_SEND_SEC_RSP));
    wire timed_entry  = entering && ((state_d == query_battery_status_state)
                      || (state_d == query_maker_info_state) || (state_d == swap_initiation_state));
    wire query_exit   = entering && ((state_q == query_battery_status_state)
                      || (state_q == query_maker_info_state));
    wire answer_send  = !sent_q && i_pm_data_ready && ((state_q == answer_battery_status_state)
                      || (state_q == answer_maker_info_state) || (state_q == ST_SEND_SEC_RSP));
    wire eval_to_rej  = (state_q == swap_evaluation_state) && (state_d == swap_reject_state);
    // wait only when more time is asked for and no refusal came with it
    msg_t rej_pick;
    assign rej_pick = (i_pm_swap_wait && !i_pm_swap_no) ? MSG_WAIT : MSG_REJECT;
    msg_t answer_msg;
    assign answer_msg = (state_q == answer_battery_status_state) ? MSG_BATT_STATUS :
                        (state_q == answer_maker_info_state)     ? MSG_MAKER_INFO  :
                                                                   MSG_SEC_RESPONSE;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_q <= ST_READY;
            sent_q  <= 1'b0;
            tmr_q   <= TMR_ZERO;
            ufp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            sent_q  <= entering ? 1'b0 : (sent_q || answer_send);
            // timer loads on entry and clears on any exit
            if (timed_entry)
                tmr_q <= RESP_CYCLES[TMR_W-1:0];
            else if (entering)
                tmr_q <= TMR_ZERO;
            else if (tmr_q != TMR_ZERO)
                tmr_q <= tmr_q - TMR_ONE;
            // role flips only on manager confirmation; hard reset reverts to DFP
            if (state_q == change_to_upstream_state && i_pm_role_done)
                ufp_q <= 1'b1;
            else if (state_q == ST_HARD_RESET && i_hard_reset_done)
                ufp_q <= 1'b0;
        end
    end

    // registered outputs; transmit requests are single-cycle pulses
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tx_req_q <= 1'b0;
            tx_msg_q <= MSG_NONE;
            fetch_q  <= 1'b0;
            eval_q   <= 1'b0;
            role_q   <= 1'b0;
            sec_q    <= 1'b0;
            out_q    <= OUT_NONE;
            outv_q   <= 1'b0;
            hr_q     <= 1'b0;
        end else begin
            tx_req_q <= (entering && tx_entry != MSG_NONE) || answer_send || eval_to_rej;
            tx_msg_q <= eval_to_rej ? rej_pick
                      : answer_send ? answer_msg
                      : (entering ? tx_entry : MSG_NONE);
            fetch_q  <= answer_entry;
            eval_q   <= entering && state_d == swap_evaluation_state;
            role_q   <= entering && state_d == change_to_upstream_state;
            sec_q    <= entering && state_d == ST_SEC_RSP_RCVD;
            outv_q   <= query_exit;
            out_q    <= query_exit ? ((rx_batt || rx_maker) ? OUT_OK : OUT_TIMEOUT) : OUT_NONE;
            hr_q     <= entering && state_d == ST_HARD_RESET;
        end
    end

    assign o_tx_req         = tx_req_q;
    assign o_tx_msg         = tx_msg_q;
    assign o_pm_fetch_req   = fetch_q;
    assign o_pm_eval_req    = eval_q;
    assign o_pm_role_req    = role_q;
    assign o_pm_sec_info    = sec_q;
    assign o_pm_outcome     = out_q;
    assign o_pm_outcome_vld = outv_q;
    assign o_hard_reset_req = hr_q;
    assign o_is_ufp         = ufp_q;
    assign o_timer_run      = (tmr_q != TMR_ZERO);

    // checks
    a_alt_mode_reset: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q == ST_READY && rx_dr_swap && i_alt_mode_active && !i_cable_plug && !ufp_q)
        |=> o_hard_reset_req) else $error("alt mode swap did not hard reset");
    a_swap_eval_ask: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q == swap_evaluation_state && $past(state_q) != swap_evaluation_state)
        |-> o_pm_eval_req) else $error("evaluation entered without asking");
    a_accept_sent: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q == swap_accept_state && $past(state_q) != swap_accept_state)
        |-> o_tx_req && o_tx_msg == MSG_ACCEPT) else $error("accept not sent");
    a_role_flip: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_is_ufp) |-> $past(state_q) == change_to_upstream_state)
        else $error("role changed outside change state");
    a_init_timer: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q != swap_initiation_state) && $past(state_q) == swap_initiation_state
        |-> !o_timer_run || state_q != ST_READY) else $error("timer not stopped");
    a_init_rej_back: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q == swap_initiation_state && rx_rej_wait && !rx_accept)
        |=> state_q == ST_READY && !o_is_ufp) else $error("reject not honoured");
    a_init_accept: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q == swap_initiation_state && rx_accept)
        |=> state_q == change_to_upstream_state && o_pm_role_req)
        else $error("accept did not reach change state");
    a_query_report: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q == query_battery_status_state && rx_batt)
        |=> state_q == ST_READY ##0 (o_pm_outcome_vld && o_pm_outcome == OUT_OK))
        else $error("battery outcome missing");
    a_sec_no_timer: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        state_q == ST_SEND_SEC_REQ |-> !o_timer_run) else $error("timer ran for security");
    a_reject_wait: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_q == swap_evaluation_state && !i_pm_swap_ok && i_pm_swap_wait && !i_pm_swap_no)
        |=> state_q == swap_reject_state && o_tx_msg == MSG_WAIT)
        else $error("wait not sent");

    c_swap_done:  cover property (@(posedge i_clk_sys) $rose(o_is_ufp));
    c_timeout:    cover property (@(posedge i_clk_sys) o_pm_outcome == OUT_TIMEOUT);
    c_hard_reset: cover property (@(posedge i_clk_sys) o_hard_reset_req);
    c_sec_rsp:    cover property (@(posedge i_clk_sys) o_pm_sec_info);
endmodule

// ===== pd_link_partner.sv
// partner model: acknowledges each transmit after i_dly + 1 cycles, then answers queries
// assumes the engine clock; transmit requests arrive as one-cycle pulses
`timescale 1ns/1ps
module pd_link_partner (
    // clock, reset and engine transmit side
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    input  wire logic             i_tx_req,
    input  wire pd_ext_pkg::msg_t i_tx_msg,
    // behaviour set by the bench
    input  wire logic [3:0]       i_dly,
    input  wire logic             i_reply_en,
    input  wire pd_ext_pkg::msg_t i_swap_reply,
    input  wire pd_ext_pkg::msg_t i_inj_msg,
    input  wire logic             i_inj_go,
    // engine receive side
    output logic                  o_tx_done,
    output pd_ext_pkg::msg_t      o_rx_msg,
    output logic                  o_rx_valid
);
    import pd_ext_pkg::*;
    logic [3:0] cnt_q;
    msg_t       pend_q, ans_q, ans_d;
    // a reply never overlaps its acknowledge; muting replies lets a query time out, a swap reply is always i_swap_reply
    assign ans_d = (pend_q == MSG_DR_SWAP) ? i_swap_reply
                 : !i_reply_en ? MSG_NONE
                 : (pend_q == MSG_GET_BATT_STATUS) ? MSG_BATT_STATUS
                 : (pend_q == MSG_GET_MAKER_INFO) ? MSG_MAKER_INFO : MSG_NONE;
    always_ff @(posedge i_clk_sys) begin
        o_tx_done  <= 1'b0;
        o_rx_valid <= 1'b0;
        o_rx_msg   <= MSG_NONE;
        if (i_sys_rst) begin
            cnt_q  <= 4'h0;
            pend_q <= MSG_NONE;
            ans_q  <= MSG_NONE;
        end else if (i_inj_go) begin
            o_rx_valid <= 1'b1;
            o_rx_msg   <= i_inj_msg;
        end else if (i_tx_req) begin
            cnt_q  <= i_dly;
            pend_q <= i_tx_msg;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (pend_q != MSG_NONE) begin
            o_tx_done <= 1'b1;
            ans_q     <= ans_d;
            pend_q    <= MSG_NONE;
            cnt_q     <= 4'h2;
        end else if (ans_q != MSG_NONE) begin
            o_rx_valid <= 1'b1;
            o_rx_msg   <= ans_q;
            ans_q      <= MSG_NONE;
        end
    end
endmodule

// ===== tb_pd_ext_engine.sv
// testbench: policy engine slice against the partner model, one task per scenario
// assumes a 200 MHz clock and a synchronous active-high reset
`timescale 1ns/1ps
module tb_pd_ext_engine;
    import pd_ext_pkg::*;
    logic        clk = 1'b0, rst = 1'b1;
    logic [11:0] pm = 12'h000;
    logic        sink = 1'b0, cable = 1'b0, alt = 1'b0, rep = 1'b1;
    logic [3:0]  dly = 4'h0;
    msg_t        sw_rep = MSG_NONE, inj = MSG_NONE, rx_msg, tx_msg, last_tx;
    outcome_t    outcome, last_out;
    logic        rx_vld, tx_done, tx_req, fetch, eval, role, sec, out_vld, hr, ufp, trun;
    // pulse counts: 0 tx, 1 fetch, 2 eval, 3 role, 4 sec info, 5 hard reset, 6 outcome
    wire  [6:0]  pulses = {out_vld, hr, sec, role, eval, fetch, tx_req};
    int          n[7] = '{default: 0};
    int          ticks = 0, bad_count = 0, comparisons = 0;
    pd_ext_engine i_pd_ext_engine (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_role_is_sink(sink), .i_cable_plug(cable),
        .i_alt_mode_active(alt), .i_hard_reset_done(pm[10]), .i_pm_get_batt(pm[0]),
        .i_pm_get_maker(pm[1]), .i_pm_send_sec(pm[2]), .i_pm_dr_swap(pm[3]),
        .i_pm_data_ready(pm[4]), .i_pm_swap_ok(pm[5]), .i_pm_swap_no(pm[6]),
        .i_pm_swap_wait(pm[7]), .i_pm_role_done(pm[8]), .i_pm_sec_ack(pm[9]),
        .i_rx_msg(rx_msg), .i_rx_valid(rx_vld), .i_tx_done(tx_done), .o_tx_req(tx_req),
        .o_tx_msg(tx_msg), .o_pm_fetch_req(fetch), .o_pm_eval_req(eval),
        .o_pm_role_req(role), .o_pm_sec_info(sec), .o_pm_outcome(outcome),
        .o_pm_outcome_vld(out_vld), .o_hard_reset_req(hr), .o_is_ufp(ufp), .o_timer_run(trun));
    pd_link_partner i_pd_link_partner (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_tx_req(tx_req), .i_tx_msg(tx_msg), .i_dly(dly),
        .i_reply_en(rep), .i_swap_reply(sw_rep), .i_inj_msg(inj), .i_inj_go(pm[11]),
        .o_tx_done(tx_done), .o_rx_msg(rx_msg), .o_rx_valid(rx_vld));
    always @(posedge clk) begin
        ticks++;
        if (tx_req === 1'b1) last_tx = tx_msg;
        if (out_vld === 1'b1) last_out = outcome;
        foreach (n[k]) n[k] += int'(pulses[k] === 1'b1);
        if (ticks > 30000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // bit 11 has the partner send inj, bit 10 is hard reset done; the other bits are manager strobes
    task automatic ks(input int b, input int c, input msg_t m = MSG_NONE, input bit fr = 0);
        if (fr) n = '{default: 0};
        inj <= m;
        @(posedge clk);
        pm[b] <= 1'b1;
        @(posedge clk);
        pm <= 12'h000;
        repeat (c) @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic s_query();
        for (int i = 0; i < 3; i++) begin
            rep <= (i != 2);
            ks(i % 2, 3, MSG_NONE, 1); chk("timer_run", 8'h01, trun);
            ks(3, i == 2 ? 6020 : 12); chk("tx_cnt", 8'h01, n[0][7:0]);
            chk("query", i == 1 ? MSG_GET_MAKER_INFO : MSG_GET_BATT_STATUS, last_tx);
            chk("outcome", i == 2 ? OUT_TIMEOUT : OUT_OK, last_out);
            chk("timer_idle", 8'h00, trun);
        end
        rep <= 1'b1;
    endtask
    task automatic s_answer();
        msg_t q[3] = '{MSG_GET_BATT_STATUS, MSG_GET_MAKER_INFO, MSG_SEC_REQUEST};
        msg_t a[3] = '{MSG_BATT_STATUS, MSG_MAKER_INFO, MSG_SEC_RESPONSE};
        dly <= 4'h6;
        sink <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            cable <= c[0];
            for (int i = 0; i < 3; i++) begin
                ks(11, 4, q[i], 1);
                chk("fetch", (c == 1 && i == 0) ? 8'h00 : 8'h01, n[1][7:0]);
                ks(4, 14); chk("answer", n[1] ? a[i] : MSG_NONE, n[0] ? last_tx : MSG_NONE);
            end
        end
        cable <= 1'b0;
        dly <= 4'h0;
    endtask
    task automatic s_sec();
        ks(2, 5, MSG_NONE, 1); chk("timer_run", 8'h00, trun);
        ks(11, 6, MSG_SEC_RESPONSE); chk("sec_req", MSG_SEC_REQUEST, last_tx);
        chk("sec_info", 8'h01, n[4][7:0]);
        ks(9, 2);
        ks(2, 8, MSG_NONE, 1); chk("tx_cnt", 8'h01, n[0][7:0]);
    endtask
    task automatic s_eval();
        do_reset();
        ks(11, 4, MSG_DR_SWAP, 1); chk("eval_req", 8'h01, n[2][7:0]);
        ks(5, 8); chk("accept", MSG_ACCEPT, last_tx);
        chk("role_req", 8'h01, n[3][7:0]);
        ks(8, 2); chk("is_ufp", 8'h01, ufp);
        ks(11, 2, MSG_DR_SWAP, 1);
        ks(3, 8); chk("ufp_swap", 8'h00, n[0][7:0] + n[2][7:0]);
    endtask
    task automatic s_refuse();
        for (int b = 6; b < 8; b++) begin
            do_reset();
            ks(11, 4, MSG_DR_SWAP, 1);
            ks(b, 8); chk("refusal", b == 6 ? MSG_REJECT : MSG_WAIT, last_tx);
            chk("is_ufp", 8'h00, ufp);
        end
    endtask
    task automatic s_alt();
        do_reset();
        alt <= 1'b1;
        ks(11, 4, MSG_DR_SWAP, 1); chk("hard_reset", 8'h01, n[5][7:0]);
        chk("eval_req", 8'h00, n[2][7:0]);
        alt <= 1'b0;
        ks(10, 2);
        ks(0, 12, MSG_NONE, 1); chk("outcome_cnt", 8'h01, n[6][7:0]);
    endtask
    task automatic s_init();
        msg_t r[4] = '{MSG_REJECT, MSG_WAIT, MSG_NONE, MSG_ACCEPT};
        do_reset();
        for (int i = 0; i < 4; i++) begin
            sw_rep <= r[i];
            ks(3, 3, MSG_NONE, 1); chk("timer_run", 8'h01, trun);
            repeat (i == 2 ? 6020 : 12) @(posedge clk);
            chk("swap_req", MSG_DR_SWAP, last_tx);
            chk("timer_stop", 8'h00, trun);
            chk("role_req", i == 3 ? 8'h01 : 8'h00, n[3][7:0]);
            chk("is_ufp", 8'h00, ufp);
        end
        ks(8, 2); chk("is_ufp", 8'h01, ufp);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        s_query();
        s_answer();
        s_sec();
        s_eval();
        s_refuse();
        s_alt();
        s_init();
        end_of_test();
    end
endmodule
